// ### rtl/power_ctl_pkg.sv
package power_ctl_pkg;
	// ==========================================
	// fuse configuration map (24-bit words, low 16 used)
	localparam logic [23:0] OSC_FUSE_ADDR = 24'hf8_0000;
	localparam logic [23:0] WDT_FUSE_ADDR = 24'hf8_0002;
	localparam logic [23:0] BORPOR_FUSE_ADDR = 24'hf8_0004;
	localparam logic [23:0] CODESEG_FUSE_ADDR = 24'hf8_000a;
	localparam logic [23:0] DEBUG_FUSE_ADDR = 24'hf8_000c;
	localparam int FUSE_WIDTH = 24;
	localparam int FUSE_DATA_WIDTH = 16;
	// watchdog fuse enable position and erased default
	localparam int WDT_FUSE_EN_BIT = 15;
	localparam logic [15:0] WDT_FUSE_ERASED = 16'h8000;
	// ==========================================
	// reset control status bit positions
	localparam int RCS_POR_BIT = 0;
	localparam int RCS_BOR_BIT = 1;
	localparam int RCS_IDLE_BIT = 2;
	localparam int RCS_SLEEP_BIT = 3;
	localparam int RCS_WATCHDOG_TIMEOUT_FLAG_BIT = 4;
	localparam int RCS_SOFT_EN_BIT = 5;
	localparam int RCS_SWR_BIT = 6;
	localparam int RCS_EXTR_BIT = 7;
	localparam logic [15:0] RCS_POR_VALUE = 16'h0003;
	// ==========================================
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int POWER_ON_DELAY_NS = 10000;
	localparam int POWER_ON_DELAY_CYC = (POWER_ON_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POWERUP_TIMER_DELAY_CYC = 64;
	localparam int PLL_LOCK_DELAY_CYC = 20;
	localparam int WDT_WIDTH = 12;
	// ==========================================
	// power-save parameter and oscillator kinds
	localparam logic PSAVE_SLEEP = 1'b0;
	localparam logic PSAVE_IDLE = 1'b1;
	typedef enum logic [1:0] {
		OSC_KIND_RC = 2'b00,
		OSC_KIND_CRYSTAL = 2'b01,
		OSC_KIND_CRYSTAL_PLL = 2'b10,
		OSC_KIND_LP_CRYSTAL = 2'b11
	} osc_kind_t;
	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_IDLE = 3'b001,
		ST_SLEEP = 3'b010,
		ST_WAKE_DELAY = 3'b011,
		ST_WAKE_OSC = 3'b100,
		ST_SUSPEND = 3'b101
	} power_state_t;
endpackage

// ### rtl/watchdog_sleep_idle_control.sv
`timescale 1ns/1ps
//Function
// R01: fuse enable bit 1 enables watchdog, erased 1
// R02: enabled counter overflow resets device outside Sleep and Idle
// R03: clear instruction restarts watchdog count
// R04: time-out in Sleep wakes, no reset
// R05: fuse 0: soft enable bit 5 controls watchdog
// R06: power-save instruction parameter selects Sleep/Idle
// R07: Sleep stops CPU, peripheral clocks, oscillator
// R08: clock monitor off in Sleep; RC runs (code keeps RC on in Sleep only while watchdog enabled)
// R09: brown-out and low-voltage detect run in Sleep
// R10: wake on interrupt, reset, or watchdog time-out
// R11: wake restarts prior clock; fuses after POR/BOR
// R12: oscillator wake waits start-up timer, PLL lock
// R13: RC/external clock wake applies only power-on delay
// R14: LP crystal running in Sleep: power-on delay only
// R15: interrupt wake from Sleep vectors, sets Sleep flag
// R16: dead oscillator: trap with monitor, else suspend
// R17: non-POR reset in Sleep sets flag; POR clears
// R18: watchdog Sleep wake sets Sleep and time-out flags
// R19: Idle stops only CPU clock
// R20: Idle wake immediate, resume after instruction
// R21: Idle flag on reset/interrupt; watchdog sets both
// R22: fuse words 24 bits, low 16 readable
// R23: separate CPU, peripheral, oscillator gate outputs
module watchdog_sleep_idle_control #(
	parameter int WDT_BITS = power_ctl_pkg::WDT_WIDTH,
	parameter int POR_CYC = power_ctl_pkg::POWER_ON_DELAY_CYC,
	parameter int POWERUP_TIMER_CYC = power_ctl_pkg::POWERUP_TIMER_DELAY_CYC,
	parameter int LOCK_CYC = power_ctl_pkg::PLL_LOCK_DELAY_CYC
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic power_on_reset,
	input wire logic brownout_reset,
	input wire logic master_clear_pin,
	input wire logic power_save_instruction,
	input wire logic power_save_param,
	input wire logic watchdog_clear_instruction,
	input wire logic low_power_rc_osc_tick,
	input wire logic irq_wake,
	input wire logic [15:0] fuse_osc,
	input wire logic [15:0] fuse_wdt,
	input wire logic [15:0] fuse_borpor,
	input wire logic [15:0] fuse_codeseg,
	input wire logic [15:0] fuse_debug,
	input wire power_ctl_pkg::osc_kind_t wake_osc_kind,
	input wire logic lp_osc_in_sleep,
	input wire logic osc_startup_done,
	input wire logic osc_running,
	input wire logic pll_locked,
	input wire logic clock_fail_monitor_en,
	input wire logic brownout_en,
	input wire logic low_voltage_detect_en,
	input wire logic rcs_wr,
	input wire logic [15:0] rcs_wdata,
	input wire logic [23:0] table_addr,
	output logic [23:0] table_rdata,
	output logic [15:0] reset_control_status,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic osc_en,
	output logic low_power_rc_osc_en,
	output logic clock_fail_monitor_active,
	output logic brownout_active,
	output logic low_voltage_detect_active,
	output logic watchdog_reset_req,
	output logic irq_vector_take,
	output logic clock_fail_trap,
	output logic fast_rc_enable,
	output logic resume_next
);
	import power_ctl_pkg::*;

	// ==========================================
	// state and watchdog
	power_state_t state, next_state;
	logic [WDT_BITS-1:0] wdt_count;
	logic [15:0] delay_count;
	logic [15:0] rcs;
	logic irq_from_sleep;
	assign reset_control_status = rcs;

	wire watchdog_fuse_enable = fuse_wdt[WDT_FUSE_EN_BIT];
	wire watchdog_soft_enable = rcs[RCS_SOFT_EN_BIT];
	wire wdt_enabled = watchdog_fuse_enable | watchdog_soft_enable; // see R01 see R05
	wire wdt_overflow = wdt_enabled & low_power_rc_osc_tick & (&wdt_count);
	wire in_sleep = (state == ST_SLEEP);
	wire in_idle = (state == ST_IDLE);
	wire ext_reset = power_on_reset | brownout_reset | master_clear_pin;
	wire wake_event = irq_wake | wdt_overflow; // see R10

	// the clear also covers the cycle of a tick so a clear never loses to the count
	always_ff @(posedge ref_clk) begin
		if (reset || ext_reset || watchdog_clear_instruction || !wdt_enabled)
			wdt_count <= '0; // see R03
		else if (low_power_rc_osc_tick)
			wdt_count <= wdt_count + 1'b1; // see R02
	end

	// overflow resets outside Sleep and Idle, wake delay and suspend states included; in Sleep or Idle it wakes instead
	assign watchdog_reset_req = wdt_overflow & ~in_sleep & ~in_idle; // see R02 see R04

	// ==========================================
	// wake delay selection
	wire fast_wake = (wake_osc_kind == OSC_KIND_RC)
		| ((wake_osc_kind == OSC_KIND_LP_CRYSTAL) & lp_osc_in_sleep); // see R13 see R14
	wire [15:0] crystal_delay = 16'(POR_CYC + POWERUP_TIMER_CYC)
		+ ((wake_osc_kind == OSC_KIND_CRYSTAL_PLL) ? 16'(LOCK_CYC) : 16'h0000); // see R12
	wire [15:0] wake_delay = fast_wake ? 16'(POR_CYC) : crystal_delay;
	wire osc_ready = osc_startup_done & ((wake_osc_kind != OSC_KIND_CRYSTAL_PLL) | pll_locked); // see R12

	// ==========================================
	// power state machine
	always_comb begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (power_save_instruction)
					next_state = (power_save_param == PSAVE_IDLE) ? ST_IDLE : ST_SLEEP; // see R06
			end
			ST_IDLE: begin
				if (wake_event)
					next_state = ST_RUN; // see R20
			end
			ST_SLEEP: begin
				if (wake_event)
					next_state = ST_WAKE_DELAY; // see R11
			end
			ST_WAKE_DELAY: begin
				if (delay_count == 16'h0000)
					next_state = fast_wake ? ST_RUN : ST_WAKE_OSC;
			end
			ST_WAKE_OSC: begin
				if (osc_ready && osc_running)
					next_state = ST_RUN;
				else if (!clock_fail_monitor_en)
					next_state = ST_SUSPEND; // see R16
				else
					next_state = ST_RUN; // see R16
			end
			ST_SUSPEND: begin
				if (osc_running)
					next_state = ST_RUN;
			end
			default: next_state = ST_RUN;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset || ext_reset)
			state <= ST_RUN;
		else
			state <= next_state;
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			delay_count <= 16'h0000;
		else if (in_sleep && wake_event)
			delay_count <= wake_delay - 16'h0001;
		else if (state == ST_WAKE_DELAY && delay_count != 16'h0000)
			delay_count <= delay_count - 16'h0001;
	end

	// remembers an interrupt wake from Sleep until the clock is back
	always_ff @(posedge ref_clk) begin
		if (reset || ext_reset)
			irq_from_sleep <= 1'b0;
		else if (in_sleep && irq_wake)
			irq_from_sleep <= 1'b1;
		else if (state != ST_SLEEP && next_state == ST_RUN)
			irq_from_sleep <= 1'b0;
	end

	// ==========================================
	// reset control status register; hardware set wins over software write
	wire clk_fail_now = (state == ST_WAKE_OSC) & ~(osc_ready & osc_running) & clock_fail_monitor_en;
	always_ff @(posedge ref_clk) begin
		if (reset || power_on_reset) begin
			rcs <= RCS_POR_VALUE; // see R17 see R21
		end else begin
			if (rcs_wr)
				rcs <= rcs_wdata;
			if (brownout_reset)
				rcs[RCS_BOR_BIT] <= 1'b1;
			if (master_clear_pin)
				rcs[RCS_EXTR_BIT] <= 1'b1;
			if ((brownout_reset || master_clear_pin) && in_sleep)
				rcs[RCS_SLEEP_BIT] <= 1'b1; // see R17
			if ((brownout_reset || master_clear_pin) && in_idle)
				rcs[RCS_IDLE_BIT] <= 1'b1; // see R21
			if (!ext_reset && in_sleep && wake_event)
				rcs[RCS_SLEEP_BIT] <= 1'b1; // see R15 see R18
			if (!ext_reset && in_idle && wake_event)
				rcs[RCS_IDLE_BIT] <= 1'b1; // see R21
			if (wdt_overflow)
				rcs[RCS_WATCHDOG_TIMEOUT_FLAG_BIT] <= 1'b1; // see R18 see R21
		end
	end

	// ==========================================
	// clock gating and event outputs
	wire stopped = in_sleep | (state == ST_WAKE_DELAY) | (state == ST_WAKE_OSC) | (state == ST_SUSPEND);
	assign cpu_clk_en = ~stopped & ~in_idle; // see R07 see R19 see R23
	assign periph_clk_en = ~stopped; // see R07 see R19 see R23
	assign osc_en = ~in_sleep; // see R07 see R23
	assign low_power_rc_osc_en = wdt_enabled | ~in_sleep; // see R08
	assign clock_fail_monitor_active = clock_fail_monitor_en & ~in_sleep; // see R08
	assign brownout_active = brownout_en; // see R09
	assign low_voltage_detect_active = low_voltage_detect_en; // see R09

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq_vector_take <= 1'b0;
			clock_fail_trap <= 1'b0;
			fast_rc_enable <= 1'b0;
			resume_next <= 1'b0;
		end else begin
			irq_vector_take <= (irq_wake & in_idle) | (irq_from_sleep & (state != ST_SLEEP)
				& (state != ST_RUN) & (next_state == ST_RUN)); // see R15
			clock_fail_trap <= clk_fail_now; // see R16
			if (clk_fail_now)
				fast_rc_enable <= 1'b1; // see R16
			else if (ext_reset)
				fast_rc_enable <= 1'b0;
			resume_next <= in_idle & wdt_overflow & ~irq_wake; // see R20
		end
	end

	// ==========================================
	// fuse table read, 24-bit words with zero upper byte
	wire [15:0] fuse_sel = (table_addr == OSC_FUSE_ADDR) ? fuse_osc
		: (table_addr == WDT_FUSE_ADDR) ? fuse_wdt
		: (table_addr == BORPOR_FUSE_ADDR) ? fuse_borpor
		: (table_addr == CODESEG_FUSE_ADDR) ? fuse_codeseg
		: (table_addr == DEBUG_FUSE_ADDR) ? fuse_debug : 16'h0000;
	always_ff @(posedge ref_clk) begin
		if (reset)
			table_rdata <= 24'h00_0000;
		else
			table_rdata <= {8'h00, fuse_sel}; // see R22
	end

	// ==========================================
	// checks
	// wake delay measured by its own counter, not by the loaded delay value
	logic [15:0] wake_cyc;
	always_ff @(posedge ref_clk) begin
		if (reset || in_sleep)
			wake_cyc <= 16'h0000;
		else if (state == ST_WAKE_DELAY)
			wake_cyc <= wake_cyc + 16'h0001;
	end

	// gating per power state
	sleep_gate_a: assert property (@(posedge ref_clk) disable iff (reset) // see R07
		in_sleep |-> !cpu_clk_en && !periph_clk_en && !osc_en)
		else $error("clocks run in sleep");
	idle_gate_a: assert property (@(posedge ref_clk) disable iff (reset) // see R19
		in_idle |-> !cpu_clk_en && periph_clk_en && osc_en)
		else $error("idle gating wrong");
	run_gates_a: assert property (@(posedge ref_clk) disable iff (reset) // see R23
		state == ST_RUN |-> cpu_clk_en && periph_clk_en && osc_en)
		else $error("run gating wrong");
	sleep_alive_a: assert property (@(posedge ref_clk) disable iff (reset) // see R08
		in_sleep && wdt_enabled |-> low_power_rc_osc_en && !clock_fail_monitor_active)
		else $error("sleep monitor wrong");
	detect_alive_a: assert property (@(posedge ref_clk) disable iff (reset) // see R09
		in_sleep |-> brownout_active == brownout_en && low_voltage_detect_active == low_voltage_detect_en)
		else $error("detectors off in sleep");
	enter_mode_a: assert property (@(posedge ref_clk) disable iff (reset) // see R06
		state == ST_RUN && power_save_instruction && !ext_reset |=>
		state == (power_save_param ? ST_IDLE : ST_SLEEP))
		else $error("wrong power state");

	// watchdog
	wdt_reset_a: assert property (@(posedge ref_clk) disable iff (reset) // see R02
		watchdog_reset_req |-> state == ST_RUN && wdt_enabled)
		else $error("bad watchdog reset");
	wdt_count_a: assert property (@(posedge ref_clk) disable iff (reset) // see R02
		wdt_enabled && low_power_rc_osc_tick && !watchdog_clear_instruction && !ext_reset |=>
		wdt_count == WDT_BITS'($past(wdt_count) + 1'b1))
		else $error("watchdog count step");
	wdt_clear_a: assert property (@(posedge ref_clk) disable iff (reset) // see R03
		watchdog_clear_instruction |=> wdt_count == '0)
		else $error("clear missed");
	wdt_off_a: assert property (@(posedge ref_clk) disable iff (reset) // see R05
		!wdt_enabled |=> wdt_count == '0)
		else $error("disabled watchdog counts");
	sleep_wdt_wake_a: assert property (@(posedge ref_clk) disable iff (reset) // see R04 see R18
		in_sleep && wdt_overflow && !ext_reset |=> rcs[RCS_SLEEP_BIT] && rcs[RCS_WATCHDOG_TIMEOUT_FLAG_BIT]
		&& !watchdog_reset_req)
		else $error("sleep wake flags");

	// wake paths
	idle_wake_a: assert property (@(posedge ref_clk) disable iff (reset) // see R20 see R21
		in_idle && wake_event && !ext_reset |=> state == ST_RUN && cpu_clk_en && rcs[RCS_IDLE_BIT])
		else $error("idle wake slow");
	idle_vector_a: assert property (@(posedge ref_clk) disable iff (reset) // see R10
		in_idle && irq_wake && !ext_reset |=> irq_vector_take)
		else $error("idle interrupt not taken");
	idle_resume_a: assert property (@(posedge ref_clk) disable iff (reset) // see R20
		in_idle && wdt_overflow && !irq_wake && !ext_reset |=> resume_next)
		else $error("idle resume missed");
	reset_wake_a: assert property (@(posedge ref_clk) disable iff (reset) // see R10
		(in_sleep || in_idle) && ext_reset |=> state == ST_RUN && cpu_clk_en)
		else $error("reset did not wake");
	sleep_irq_a: assert property (@(posedge ref_clk) disable iff (reset) // see R15
		in_sleep && irq_wake && !ext_reset |=> state == ST_WAKE_DELAY && rcs[RCS_SLEEP_BIT])
		else $error("sleep interrupt wake");
	set_wins_a: assert property (@(posedge ref_clk) disable iff (reset) // see R15
		rcs_wr && in_sleep && irq_wake && !ext_reset |=> rcs[RCS_SLEEP_BIT])
		else $error("write beat flag set");
	fast_wake_a: assert property (@(posedge ref_clk) disable iff (reset) // see R13 see R14
		state == ST_WAKE_DELAY && delay_count == 16'h0000 && fast_wake |-> wake_cyc == 16'(POR_CYC - 1))
		else $error("fast wake delay");
	crystal_wake_a: assert property (@(posedge ref_clk) disable iff (reset) // see R12
		state == ST_WAKE_DELAY && delay_count == 16'h0000 && !fast_wake |-> wake_cyc == 16'(POR_CYC + POWERUP_TIMER_CYC - 1)
		+ ((wake_osc_kind == OSC_KIND_CRYSTAL_PLL) ? 16'(LOCK_CYC) : 16'h0000))
		else $error("crystal wake delay");

	// dead oscillator after the wake delay
	osc_suspend_a: assert property (@(posedge ref_clk) disable iff (reset) // see R16
		state == ST_WAKE_OSC && !(osc_ready && osc_running) && !clock_fail_monitor_en && !ext_reset
		|=> state == ST_SUSPEND)
		else $error("no suspend");
	clk_trap_a: assert property (@(posedge ref_clk) disable iff (reset) // see R16
		state == ST_WAKE_OSC && !(osc_ready && osc_running) && clock_fail_monitor_en && !ext_reset
		|=> clock_fail_trap && fast_rc_enable && state == ST_RUN)
		else $error("no clock fail trap");
	suspend_hold_a: assert property (@(posedge ref_clk) disable iff (reset) // see R16
		state == ST_SUSPEND && !osc_running && !ext_reset |=> state == ST_SUSPEND && !cpu_clk_en)
		else $error("left suspend early");

	// status and fuse reads
	por_clear_a: assert property (@(posedge ref_clk) disable iff (reset) // see R17
		power_on_reset |=> !rcs[RCS_SLEEP_BIT] && !rcs[RCS_IDLE_BIT] && rcs == RCS_POR_VALUE)
		else $error("por flags");
	fuse_read_a: assert property (@(posedge ref_clk) disable iff (reset) // see R22
		table_addr == WDT_FUSE_ADDR |=> table_rdata == {8'h00, $past(fuse_wdt)})
		else $error("fuse read");
	fuse_osc_read_a: assert property (@(posedge ref_clk) disable iff (reset) // see R22
		table_addr == OSC_FUSE_ADDR |=> table_rdata == {8'h00, $past(fuse_osc)})
		else $error("oscillator fuse read");

	sleep_cov: cover property (@(posedge ref_clk) in_sleep ##1 state == ST_WAKE_DELAY);
	idle_cov: cover property (@(posedge ref_clk) in_idle ##1 state == ST_RUN);
	trap_cov: cover property (@(posedge ref_clk) clock_fail_trap);
	suspend_cov: cover property (@(posedge ref_clk) state == ST_SUSPEND);
	wdt_wake_cov: cover property (@(posedge ref_clk) in_sleep && wdt_overflow);
endmodule // watchdog_sleep_idle_control

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
	import power_ctl_pkg::*;
	// ==========================================
	// short counts keep the run brief; expectations derive from these
	localparam int POR = 10;
	localparam int POWERUP_TIMER = 8;
	localparam int LOCK = 4;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic power_on_reset = 1'b0, brownout_reset = 1'b0, master_clear_pin = 1'b0;
	logic power_save_instruction = 1'b0, power_save_param = 1'b0, watchdog_clear_instruction = 1'b0;
	logic low_power_rc_osc_tick = 1'b0, irq_wake = 1'b0, lp_osc_in_sleep = 1'b0;
	logic [15:0] fuse_osc = 16'h1234, fuse_wdt = 16'h8000, fuse_borpor = 16'h5a5a;
	logic [15:0] fuse_codeseg = 16'h0003, fuse_debug = 16'hc0c3, rcs_wdata = 16'h0000;
	osc_kind_t wake_osc_kind = OSC_KIND_RC;
	logic osc_startup_done = 1'b1, osc_running = 1'b1, pll_locked = 1'b1, clock_fail_monitor_en = 1'b1;
	logic brownout_en = 1'b1, low_voltage_detect_en = 1'b1, rcs_wr = 1'b0;
	logic [23:0] table_addr = 24'h00_0000;
	logic [23:0] table_rdata;
	logic [15:0] reset_control_status;
	logic cpu_clk_en, periph_clk_en, osc_en, low_power_rc_osc_en, clock_fail_monitor_active, brownout_active;
	logic low_voltage_detect_active, watchdog_reset_req, irq_vector_take, clock_fail_trap, fast_rc_enable, resume_next;
	logic saw_vec, saw_res, saw_wrst, saw_trap;
	int errors = 0;
	int num_checks = 0;
	int n;
	logic [23:0] taddr [6] = '{OSC_FUSE_ADDR, WDT_FUSE_ADDR, BORPOR_FUSE_ADDR, CODESEG_FUSE_ADDR, DEBUG_FUSE_ADDR, 24'hf8_0006};
	logic [23:0] texp [6] = '{24'h00_1234, 24'h00_8000, 24'h00_5a5a, 24'h00_0003, 24'h00_c0c3, 24'h00_0000};

	watchdog_sleep_idle_control #(.WDT_BITS(3), .POR_CYC(POR), .POWERUP_TIMER_CYC(POWERUP_TIMER), .LOCK_CYC(LOCK))
		watchdog_sleep_idle_control_inst (.ref_clk(ref_clk), .reset(reset), .power_on_reset(power_on_reset),
		.brownout_reset(brownout_reset), .master_clear_pin(master_clear_pin),
		.power_save_instruction(power_save_instruction), .power_save_param(power_save_param),
		.watchdog_clear_instruction(watchdog_clear_instruction), .low_power_rc_osc_tick(low_power_rc_osc_tick), .irq_wake(irq_wake),
		.fuse_osc(fuse_osc), .fuse_wdt(fuse_wdt), .fuse_borpor(fuse_borpor), .fuse_codeseg(fuse_codeseg),
		.fuse_debug(fuse_debug), .wake_osc_kind(wake_osc_kind), .lp_osc_in_sleep(lp_osc_in_sleep),
		.osc_startup_done(osc_startup_done), .osc_running(osc_running), .pll_locked(pll_locked),
		.clock_fail_monitor_en(clock_fail_monitor_en), .brownout_en(brownout_en),
		.low_voltage_detect_en(low_voltage_detect_en), .rcs_wr(rcs_wr), .rcs_wdata(rcs_wdata),
		.table_addr(table_addr), .table_rdata(table_rdata), .reset_control_status(reset_control_status),
		.cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_en(osc_en), .low_power_rc_osc_en(low_power_rc_osc_en),
		.clock_fail_monitor_active(clock_fail_monitor_active), .brownout_active(brownout_active),
		.low_voltage_detect_active(low_voltage_detect_active), .watchdog_reset_req(watchdog_reset_req),
		.irq_vector_take(irq_vector_take), .clock_fail_trap(clock_fail_trap), .fast_rc_enable(fast_rc_enable),
		.resume_next(resume_next));

	always #50 ref_clk = ~ref_clk;

	// one-cycle pulses are caught here so a test may look for them later
	always @(posedge ref_clk) begin
		if (irq_vector_take === 1'b1) saw_vec <= 1'b1;
		if (resume_next === 1'b1) saw_res <= 1'b1;
		if (watchdog_reset_req === 1'b1) saw_wrst <= 1'b1;
		if (clock_fail_trap === 1'b1) saw_trap <= 1'b1;
	end

	// ==========================================
	// access tasks
	task tick(input int k);
		repeat (k) begin
			@(posedge ref_clk);
			#1;
		end
	endtask
	task check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task clr_flags;
		saw_vec = 1'b0;
		saw_res = 1'b0;
		saw_wrst = 1'b0;
		saw_trap = 1'b0;
	endtask
	task do_reset;
		reset = 1'b1;
		tick(2);
		reset = 1'b0;
		tick(1);
	endtask
	task psave(input logic p);
		power_save_param = p;
		power_save_instruction = 1'b1;
		tick(1);
		power_save_instruction = 1'b0;
		tick(1);
	endtask
	task write_rcs(input logic [15:0] v);
		rcs_wdata = v;
		rcs_wr = 1'b1;
		tick(1);
		rcs_wr = 1'b0;
		tick(1);
	endtask
	task wdt_clear;
		watchdog_clear_instruction = 1'b1;
		tick(1);
		watchdog_clear_instruction = 1'b0;
		tick(1);
	endtask
	task low_power_rc_osc(input int k);
		repeat (k) begin
			low_power_rc_osc_tick = 1'b1;
			tick(1);
			low_power_rc_osc_tick = 1'b0;
			tick(1);
		end
	endtask
	task wait_run;
		n = 0;
		while (cpu_clk_en !== 1'b1 && n < 500) begin
			tick(1);
			n++;
		end
	endtask
	task sleep_wake(input osc_kind_t k, input int lo);
		wake_osc_kind = k;
		write_rcs(16'h0000);
		clr_flags();
		psave(PSAVE_SLEEP);
		check("sleep_gates", 24'({cpu_clk_en, periph_clk_en, osc_en, clock_fail_monitor_active}), 24'h00_0000);
		check("sleep_alive", 24'({low_power_rc_osc_en, brownout_active, low_voltage_detect_active}), 24'h00_0007);
		irq_wake = 1'b1;
		wait_run();
		irq_wake = 1'b0;
		tick(2);
		check("wake_cycles", 24'(n >= lo && n <= lo + 4), 24'h00_0001);
		check("irq_vector", 24'(saw_vec), 24'h00_0001);
		check("sleep_flag", 24'(reset_control_status & 16'h001c), 24'h00_0008);
	endtask

	// ==========================================
	// tests
	initial begin
		tick(2);
		reset = 1'b0;
		tick(1);
		check("rcs_reset", 24'(reset_control_status), 24'h00_0003);
		for (int i = 0; i < 6; i++) begin
			table_addr = taddr[i];
			tick(1);
			check("table_rdata", table_rdata, texp[i]);
		end
		$display("test reset_table done");
		sleep_wake(OSC_KIND_RC, POR);
		lp_osc_in_sleep = 1'b1;
		sleep_wake(OSC_KIND_LP_CRYSTAL, POR);
		sleep_wake(OSC_KIND_CRYSTAL, POR + POWERUP_TIMER);
		sleep_wake(OSC_KIND_CRYSTAL_PLL, POR + POWERUP_TIMER + LOCK);
		$display("test sleep_wake done");
		write_rcs(16'h0000);
		clr_flags();
		psave(PSAVE_IDLE);
		psave(PSAVE_SLEEP);
		check("idle_gates", 24'({cpu_clk_en, periph_clk_en, osc_en}), 24'h00_0003);
		irq_wake = 1'b1;
		tick(2);
		irq_wake = 1'b0;
		check("idle_wake", 24'({cpu_clk_en, saw_vec}), 24'h00_0003);
		check("idle_flag", 24'(reset_control_status & 16'h001c), 24'h00_0004);
		$display("test idle done");
		wdt_clear();
		clr_flags();
		low_power_rc_osc(6);
		wdt_clear();
		low_power_rc_osc(6);
		check("wdt_cleared", 24'(saw_wrst), 24'h00_0000);
		low_power_rc_osc(2);
		check("wdt_overflow", 24'(saw_wrst), 24'h00_0001);
		do_reset();
		write_rcs(16'h0000);
		wdt_clear();
		clr_flags();
		psave(PSAVE_SLEEP);
		low_power_rc_osc(9);
		wait_run();
		check("wdt_sleep", 24'({saw_wrst, reset_control_status[4:2]}), 24'h00_0006);
		write_rcs(16'h0000);
		wdt_clear();
		clr_flags();
		psave(PSAVE_IDLE);
		low_power_rc_osc(9);
		check("wdt_idle", 24'({cpu_clk_en, saw_wrst, saw_res, reset_control_status[4:2]}), 24'h00_002d);
		fuse_wdt = 16'h0000;
		write_rcs(16'h0000);
		wdt_clear();
		low_power_rc_osc(9);
		check("soft_off", 24'(saw_wrst), 24'h00_0000);
		write_rcs(16'h0020);
		check("soft_bit", 24'(reset_control_status[5]), 24'h00_0001);
		low_power_rc_osc(9);
		check("soft_on", 24'(saw_wrst), 24'h00_0001);
		fuse_wdt = 16'h8000;
		do_reset();
		$display("test watchdog done");
		write_rcs(16'h0000);
		psave(PSAVE_SLEEP);
		master_clear_pin = 1'b1;
		tick(1);
		master_clear_pin = 1'b0;
		wait_run();
		check("master_clear_pin_sleep", 24'({cpu_clk_en, reset_control_status[3]}), 24'h00_0003);
		write_rcs(16'h0000);
		psave(PSAVE_IDLE);
		brownout_reset = 1'b1;
		tick(1);
		brownout_reset = 1'b0;
		tick(2);
		check("bor_idle", 24'(reset_control_status[2]), 24'h00_0001);
		power_on_reset = 1'b1;
		tick(1);
		power_on_reset = 1'b0;
		tick(2);
		check("por_clear", 24'(reset_control_status), 24'h00_0003);
		$display("test resets done");
		wake_osc_kind = OSC_KIND_CRYSTAL;
		osc_running = 1'b0;
		clock_fail_monitor_en = 1'b0;
		psave(PSAVE_SLEEP);
		irq_wake = 1'b1;
		tick(1);
		irq_wake = 1'b0;
		tick(POR + POWERUP_TIMER + 10);
		check("suspend", 24'(cpu_clk_en), 24'h00_0000);
		osc_running = 1'b1;
		wait_run();
		check("resume", 24'(cpu_clk_en), 24'h00_0001);
		clock_fail_monitor_en = 1'b1;
		osc_running = 1'b0;
		clr_flags();
		psave(PSAVE_SLEEP);
		irq_wake = 1'b1;
		tick(1);
		irq_wake = 1'b0;
		tick(POR + POWERUP_TIMER + 10);
		check("fail_trap", 24'({saw_trap, fast_rc_enable}), 24'h00_0003);
		$display("test clock_fail done");
		results();
	end

	// a hang would otherwise stall the run; the tests need about 350 cycles
	initial begin
		repeat (6000) @(posedge ref_clk);
		errors++;
		$display("Error watchdog expected finish seen timeout");
		results();
	end

	task results;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
endmodule // tb
